// ===== hw/aplp_pkg.sv
// constants for the alarm polarity, mask and high-speed divider block
// What this block does
// - clock-active pin polarity from bit 3
// - bit 2 sets both clock-bad pin polarities
// - bit 1 sets lock-loss pin polarity
// - bit 0 sets interrupt pin polarity
// - bit 2 masks second-input signal-loss flag
// - bit 1 masks first-input signal-loss flag
// - bit 0 masks reference signal-loss flag
// - bit 2 masks second-input offset flag
// - bit 1 masks first-input offset flag
// - bit 0 masks lock-loss flag
// - mask writes never change latched flags
// - divider code plus four gives ratio
// - polarity register resets to 0xDF
// - offset/lock mask resets to 0x3F
// - divider register resets to 0x20
// - interrupt on shared pin when enabled
// - lock-loss pin tristated unless enabled
package aplp_pkg;
    // register offsets
    localparam logic [7:0] OFS_POLARITY = 8'h16;
    localparam logic [7:0] OFS_LOSS_MASK = 8'h17;
    localparam logic [7:0] OFS_OFFSET_MASK = 8'h18;
    localparam logic [7:0] OFS_HS_DIVIDER = 8'h19;
    // reset values
    localparam logic [7:0] RST_POLARITY = 8'hDF;
    localparam logic [7:0] RST_LOSS_MASK = 8'h1F;
    localparam logic [7:0] RST_OFFSET_MASK = 8'h3F;
    localparam logic [7:0] RST_HS_DIVIDER = 8'h20;
    // writable bits of each register, the rest are reserved
    localparam logic [7:0] WR_POLARITY = 8'h0F;
    localparam logic [7:0] WR_LOSS_MASK = 8'h07;
    localparam logic [7:0] WR_OFFSET_MASK = 8'h07;
    localparam logic [7:0] WR_HS_DIVIDER = 8'hE0;
    // polarity field positions
    localparam int POS_CLOCK_ACTIVE_POL = 3;
    localparam int POS_CLOCK_BAD_POL = 2;
    localparam int POS_LOCK_LOSS_POL = 1;
    localparam int POS_INTERRUPT_POL = 0;
    // signal-loss mask positions
    localparam int POS_SECOND_LOSS_MSK = 2;
    localparam int POS_FIRST_LOSS_MSK = 1;
    localparam int POS_REF_LOSS_MSK = 0;
    // offset and lock mask positions
    localparam int POS_SECOND_OFFSET_MSK = 2;
    localparam int POS_FIRST_OFFSET_MSK = 1;
    localparam int POS_LOCK_LOSS_MSK = 0;
    // high-speed divider field
    localparam int POS_HS_DIV_LSB = 5;
    localparam int HS_DIV_W = 3;
    localparam logic [3:0] HS_DIV_BASE = 4'h4;
    // read data for an unmapped offset
    localparam logic [7:0] RD_UNMAPPED = 8'h00;
endpackage

// ===== hw/aplp_pin_if.sv
// status levels, enables and polarities handed to the pin driver
`timescale 1ns/1ps
interface aplp_pin_if;
    logic interrupt_req; // unmasked alarm summary, active high
    logic first_clock_bad; // first input bad, active high
    logic second_clock_bad; // second input bad, active high
    logic clock_active; // clock-active status, active high
    logic lock_loss; // lock-loss status, active high
    logic interrupt_pin_en; // interrupt shown on shared pin
    logic first_bad_pin_en; // first clock-bad shown on shared pin when interrupt_pin_en is low
    logic second_bad_pin_en; // second clock-bad pin enable
    logic lock_loss_pin_en; // lock-loss pin enable
    logic clock_active_pin_en; // clock-active pin enable
    logic [3:0] polarity; // polarity field of the polarity register
    // register side drives, pin side reads
    modport src (
        output interrupt_req, first_clock_bad, second_clock_bad,
        output clock_active, lock_loss, interrupt_pin_en,
        output first_bad_pin_en, second_bad_pin_en, lock_loss_pin_en,
        output clock_active_pin_en, polarity
    );
    modport drv (
        input interrupt_req, first_clock_bad, second_clock_bad,
        input clock_active, lock_loss, interrupt_pin_en,
        input first_bad_pin_en, second_bad_pin_en, lock_loss_pin_en,
        input clock_active_pin_en, polarity
    );
endinterface

// ===== hw/aplp_pin_drive.sv
// registered status pin drivers with polarity and enable
`timescale 1ns/1ps
module aplp_pin_drive (
    // clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // status and configuration
    aplp_pin_if.drv pins,
    // shared interrupt / first clock-bad pin
    output logic interrupt_or_first_clock_bad_pin_o,
    output logic interrupt_or_first_clock_bad_pin_oe_o,
    // second clock-bad pin
    output logic second_clock_bad_pin_o,
    output logic second_clock_bad_pin_oe_o,
    // clock-active pin
    output logic clock_select_or_active_pin_o,
    output logic clock_select_or_active_pin_oe_o,
    // lock-loss pin
    output logic lock_loss_pin_o,
    output logic lock_loss_pin_oe_o
);
    // active-high status to pin level; polarity 1 keeps it high when set
    function automatic logic pin_level(input logic status, input logic pol);
        pin_level = pol ? status : ~status;
    endfunction

    // shared pin: interrupt wins when its enable is set
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            interrupt_or_first_clock_bad_pin_o <= 1'b0;
            interrupt_or_first_clock_bad_pin_oe_o <= 1'b0;
        end else if (pins.interrupt_pin_en) begin
            interrupt_or_first_clock_bad_pin_o <= pin_level(
                pins.interrupt_req,
                pins.polarity[aplp_pkg::POS_INTERRUPT_POL]);
            interrupt_or_first_clock_bad_pin_oe_o <= 1'b1;
        end else if (pins.first_bad_pin_en) begin
            interrupt_or_first_clock_bad_pin_o <= pin_level(
                pins.first_clock_bad,
                pins.polarity[aplp_pkg::POS_CLOCK_BAD_POL]);
            interrupt_or_first_clock_bad_pin_oe_o <= 1'b1;
        end else begin
            interrupt_or_first_clock_bad_pin_o <= 1'b0;
            interrupt_or_first_clock_bad_pin_oe_o <= 1'b0;
        end
    end

    // second clock-bad pin
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            second_clock_bad_pin_o <= 1'b0;
            second_clock_bad_pin_oe_o <= 1'b0;
        end else begin
            second_clock_bad_pin_o <= pin_level(pins.second_clock_bad,
                pins.polarity[aplp_pkg::POS_CLOCK_BAD_POL]);
            second_clock_bad_pin_oe_o <= pins.second_bad_pin_en;
        end
    end

    // clock-active pin
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            clock_select_or_active_pin_o <= 1'b0;
            clock_select_or_active_pin_oe_o <= 1'b0;
        end else begin
            clock_select_or_active_pin_o <= pin_level(pins.clock_active,
                pins.polarity[aplp_pkg::POS_CLOCK_ACTIVE_POL]);
            clock_select_or_active_pin_oe_o <= pins.clock_active_pin_en;
        end
    end

    // lock-loss pin
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            lock_loss_pin_o <= 1'b0;
            lock_loss_pin_oe_o <= 1'b0;
        end else begin
            lock_loss_pin_o <= pin_level(pins.lock_loss,
                pins.polarity[aplp_pkg::POS_LOCK_LOSS_POL]);
            lock_loss_pin_oe_o <= pins.lock_loss_pin_en;
        end
    end
endmodule

// ===== hw/aplp_alarm_config.sv
// alarm pin polarity, interrupt masks and high-speed divider registers
`timescale 1ns/1ps
module aplp_alarm_config #(
    parameter int ADDR_W = 8 // width of the register offset
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // register port from the serial host interface
    input wire logic [ADDR_W-1:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    // latched alarm flags: [2] second, [1] first, [0] reference
    input wire logic [2:0] signal_loss_flags_i,
    // latched flags: [2] second offset, [1] first offset, [0] lock loss
    input wire logic [2:0] offset_lock_flags_i,
    // live status from the monitors, active high
    input wire logic first_clock_bad_i,
    input wire logic second_clock_bad_i,
    input wire logic clock_active_i,
    input wire logic lock_loss_status_i,
    // pin enables held elsewhere
    input wire logic interrupt_pin_enable_i,
    input wire logic first_clock_bad_pin_enable_i,
    input wire logic second_clock_bad_pin_enable_i,
    input wire logic lock_loss_pin_enable_i,
    input wire logic clock_active_pin_enable_i,
    // status pins, each as level and output enable
    output logic interrupt_or_first_clock_bad_pin_o,
    output logic interrupt_or_first_clock_bad_pin_oe_o,
    output logic second_clock_bad_pin_o,
    output logic second_clock_bad_pin_oe_o,
    output logic clock_select_or_active_pin_o,
    output logic clock_select_or_active_pin_oe_o,
    output logic lock_loss_pin_o,
    output logic lock_loss_pin_oe_o,
    // internal interrupt summary, active high
    output logic interrupt_o,
    // high-speed divider to both low-speed dividers
    output logic [2:0] highspeed_output_divider_code_o,
    output logic [3:0] highspeed_divide_ratio_o
);
    // offsets up to 0x19 need at least five address bits
    if (ADDR_W < 5 || ADDR_W > 8) begin : g_bad_addr_w
        $error("ADDR_W must lie between 5 and 8");
    end

    // the four configuration registers
    logic [7:0] polarity_reg;
    logic [7:0] loss_mask_reg;
    logic [7:0] offset_mask_reg;
    logic [7:0] hs_divider_reg;
    // unmasked alarm summary
    logic interrupt_reg;
    logic interrupt_next;
    // offset widened to the package width
    logic [7:0] addr_full;

    // carrier to the pin drivers
    aplp_pin_if pin_bus ();

    // merge writable bits, reserved bits keep their constant value
    function automatic logic [7:0] merge_write(input logic [7:0] old_val,
        input logic [7:0] wdata, input logic [7:0] wr_mask);
        merge_write = (old_val & ~wr_mask) | (wdata & wr_mask);
    endfunction

    // decode one register offset
    function automatic logic hit(input logic [7:0] addr,
        input logic [7:0] ofs);
        hit = (addr == ofs);
    endfunction

    assign addr_full = 8'(reg_addr_i);

    // polarity register
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            polarity_reg <= aplp_pkg::RST_POLARITY;
        end else if (reg_wr_i && hit(addr_full, aplp_pkg::OFS_POLARITY)) begin
            polarity_reg <= merge_write(polarity_reg, reg_wdata_i,
                aplp_pkg::WR_POLARITY);
        end
    end

    // signal-loss mask register
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            loss_mask_reg <= aplp_pkg::RST_LOSS_MASK;
        end else if (reg_wr_i && hit(addr_full, aplp_pkg::OFS_LOSS_MASK)) begin
            loss_mask_reg <= merge_write(loss_mask_reg, reg_wdata_i,
                aplp_pkg::WR_LOSS_MASK);
        end
    end

    // offset and lock mask register
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            offset_mask_reg <= aplp_pkg::RST_OFFSET_MASK;
        end else if (reg_wr_i &&
                     hit(addr_full, aplp_pkg::OFS_OFFSET_MASK)) begin
            offset_mask_reg <= merge_write(offset_mask_reg, reg_wdata_i,
                aplp_pkg::WR_OFFSET_MASK);
        end
    end

    // high-speed divider register
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            hs_divider_reg <= aplp_pkg::RST_HS_DIVIDER;
        end else if (reg_wr_i && hit(addr_full, aplp_pkg::OFS_HS_DIVIDER)) begin
            hs_divider_reg <= merge_write(hs_divider_reg, reg_wdata_i,
                aplp_pkg::WR_HS_DIVIDER);
        end
    end

    // read data, one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            reg_rdata_o <= aplp_pkg::RD_UNMAPPED;
        end else if (reg_rd_i) begin
            case (addr_full)
                aplp_pkg::OFS_POLARITY: begin
                    reg_rdata_o <= polarity_reg;
                end
                aplp_pkg::OFS_LOSS_MASK: begin
                    reg_rdata_o <= loss_mask_reg;
                end
                aplp_pkg::OFS_OFFSET_MASK: begin
                    reg_rdata_o <= offset_mask_reg;
                end
                aplp_pkg::OFS_HS_DIVIDER: begin
                    reg_rdata_o <= hs_divider_reg;
                end
                default: begin
                    reg_rdata_o <= aplp_pkg::RD_UNMAPPED;
                end
            endcase
        end
    end

    // flags are inputs only; masks gate them and never write them back
    always_comb begin
        interrupt_next = 1'b0;
        if (!loss_mask_reg[aplp_pkg::POS_SECOND_LOSS_MSK]) begin
            interrupt_next = interrupt_next | signal_loss_flags_i[2];
        end
        if (!loss_mask_reg[aplp_pkg::POS_FIRST_LOSS_MSK]) begin
            interrupt_next = interrupt_next | signal_loss_flags_i[1];
        end
        if (!loss_mask_reg[aplp_pkg::POS_REF_LOSS_MSK]) begin
            interrupt_next = interrupt_next | signal_loss_flags_i[0];
        end
        if (!offset_mask_reg[aplp_pkg::POS_SECOND_OFFSET_MSK]) begin
            interrupt_next = interrupt_next | offset_lock_flags_i[2];
        end
        if (!offset_mask_reg[aplp_pkg::POS_FIRST_OFFSET_MSK]) begin
            interrupt_next = interrupt_next | offset_lock_flags_i[1];
        end
        if (!offset_mask_reg[aplp_pkg::POS_LOCK_LOSS_MSK]) begin
            interrupt_next = interrupt_next | offset_lock_flags_i[0];
        end
    end

    // registered interrupt summary
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            interrupt_reg <= 1'b0;
        end else begin
            interrupt_reg <= interrupt_next;
        end
    end

    // interrupt summary output
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            interrupt_o <= 1'b0;
        end else begin
            interrupt_o <= interrupt_next;
        end
    end

    // divider code and ratio outputs
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            highspeed_output_divider_code_o <= aplp_pkg::RST_HS_DIVIDER[
                aplp_pkg::POS_HS_DIV_LSB +: aplp_pkg::HS_DIV_W];
            highspeed_divide_ratio_o <= aplp_pkg::HS_DIV_BASE + 4'(
                aplp_pkg::RST_HS_DIVIDER[
                aplp_pkg::POS_HS_DIV_LSB +: aplp_pkg::HS_DIV_W]);
        end else begin
            highspeed_output_divider_code_o <= hs_divider_reg[
                aplp_pkg::POS_HS_DIV_LSB +: aplp_pkg::HS_DIV_W];
            highspeed_divide_ratio_o <= aplp_pkg::HS_DIV_BASE + 4'(
                hs_divider_reg[
                aplp_pkg::POS_HS_DIV_LSB +: aplp_pkg::HS_DIV_W]);
        end
    end

    // hand status, enables and polarity to the pin drivers
    assign pin_bus.interrupt_req = interrupt_reg;
    assign pin_bus.first_clock_bad = first_clock_bad_i;
    assign pin_bus.second_clock_bad = second_clock_bad_i;
    assign pin_bus.clock_active = clock_active_i;
    assign pin_bus.lock_loss = lock_loss_status_i;
    assign pin_bus.interrupt_pin_en = interrupt_pin_enable_i;
    assign pin_bus.first_bad_pin_en = first_clock_bad_pin_enable_i;
    assign pin_bus.second_bad_pin_en = second_clock_bad_pin_enable_i;
    assign pin_bus.lock_loss_pin_en = lock_loss_pin_enable_i;
    assign pin_bus.clock_active_pin_en = clock_active_pin_enable_i;
    assign pin_bus.polarity = polarity_reg[3:0];

    // registered pin drivers
    aplp_pin_drive u_pin_drive (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .pins(pin_bus.drv),
        .interrupt_or_first_clock_bad_pin_o(
            interrupt_or_first_clock_bad_pin_o),
        .interrupt_or_first_clock_bad_pin_oe_o(
            interrupt_or_first_clock_bad_pin_oe_o),
        .second_clock_bad_pin_o(second_clock_bad_pin_o),
        .second_clock_bad_pin_oe_o(second_clock_bad_pin_oe_o),
        .clock_select_or_active_pin_o(clock_select_or_active_pin_o),
        .clock_select_or_active_pin_oe_o(clock_select_or_active_pin_oe_o),
        .lock_loss_pin_o(lock_loss_pin_o),
        .lock_loss_pin_oe_o(lock_loss_pin_oe_o)
    );
endmodule

// ===== sim/aplp_alarm_config_props.sv
// concurrent checks on the ports of the alarm configuration block
`timescale 1ns/1ps
module aplp_alarm_config_chk #(
    parameter int ADDR_W = 8 // width of the register offset
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // register port
    input wire logic [ADDR_W-1:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    // flags, status and enables
    input wire logic [2:0] signal_loss_flags_i,
    input wire logic [2:0] offset_lock_flags_i,
    input wire logic first_clock_bad_i,
    input wire logic second_clock_bad_i,
    input wire logic clock_active_i,
    input wire logic lock_loss_status_i,
    input wire logic interrupt_pin_enable_i,
    input wire logic first_clock_bad_pin_enable_i,
    input wire logic second_clock_bad_pin_enable_i,
    input wire logic lock_loss_pin_enable_i,
    input wire logic clock_active_pin_enable_i,
    // pins and summaries
    input wire logic interrupt_or_first_clock_bad_pin_o,
    input wire logic interrupt_or_first_clock_bad_pin_oe_o,
    input wire logic second_clock_bad_pin_o,
    input wire logic second_clock_bad_pin_oe_o,
    input wire logic clock_select_or_active_pin_o,
    input wire logic clock_select_or_active_pin_oe_o,
    input wire logic lock_loss_pin_o,
    input wire logic lock_loss_pin_oe_o,
    input wire logic interrupt_o,
    input wire logic [2:0] highspeed_output_divider_code_o,
    input wire logic [3:0] highspeed_divide_ratio_o
);
    // shadow registers kept from host writes
    logic [7:0] pol_reg, los_reg, ofs_reg, div_reg;
    logic int_calc; // expected interrupt summary
    logic [7:0] rd_calc; // expected read data
    // only writable bits change, reserved bits keep their reset value
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            pol_reg <= aplp_pkg::RST_POLARITY;
            los_reg <= aplp_pkg::RST_LOSS_MASK;
            ofs_reg <= aplp_pkg::RST_OFFSET_MASK;
            div_reg <= aplp_pkg::RST_HS_DIVIDER;
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                aplp_pkg::OFS_POLARITY: pol_reg[3:0] <= reg_wdata_i[3:0];
                aplp_pkg::OFS_LOSS_MASK: los_reg[2:0] <= reg_wdata_i[2:0];
                aplp_pkg::OFS_OFFSET_MASK: ofs_reg[2:0] <= reg_wdata_i[2:0];
                aplp_pkg::OFS_HS_DIVIDER: div_reg[7:5] <= reg_wdata_i[7:5];
                default: ;
            endcase
        end
    end
    // unmasked flags ored together
    assign int_calc = |(signal_loss_flags_i & ~los_reg[2:0])
        | |(offset_lock_flags_i & ~ofs_reg[2:0]);
    // read mux, unmapped offsets read zero
    always_comb begin
        case (reg_addr_i)
            aplp_pkg::OFS_POLARITY: rd_calc = pol_reg;
            aplp_pkg::OFS_LOSS_MASK: rd_calc = los_reg;
            aplp_pkg::OFS_OFFSET_MASK: rd_calc = ofs_reg;
            aplp_pkg::OFS_HS_DIVIDER: rd_calc = div_reg;
            default: rd_calc = 8'h00;
        endcase
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    AST_INT_SUM: assert property (!$past(sys_rst_i) |->
        interrupt_o == $past(int_calc)) else $error("interrupt summary wrong");
    AST_INT_PIN: assert property (!$past(sys_rst_i)
        && $past(interrupt_pin_enable_i) |->
        interrupt_or_first_clock_bad_pin_oe_o
        && interrupt_or_first_clock_bad_pin_o
        == ($past(interrupt_o) ~^ $past(pol_reg[0])))
        else $error("interrupt pin level wrong");
    AST_SHARED_BAD: assert property (!$past(sys_rst_i)
        && !$past(interrupt_pin_enable_i) |->
        interrupt_or_first_clock_bad_pin_oe_o
        == $past(first_clock_bad_pin_enable_i)
        && interrupt_or_first_clock_bad_pin_o
        == ($past(first_clock_bad_pin_enable_i)
        && ($past(first_clock_bad_i) ~^ $past(pol_reg[2]))))
        else $error("shared pin clock-bad level wrong");
    // these three pins keep showing their level while released
    AST_SECOND_BAD: assert property (!sys_rst_i |=>
        second_clock_bad_pin_oe_o == $past(second_clock_bad_pin_enable_i)
        && second_clock_bad_pin_o
        == ($past(second_clock_bad_i) ~^ $past(pol_reg[2])))
        else $error("second clock-bad pin wrong");
    AST_LOCK_PIN: assert property (!sys_rst_i |=>
        lock_loss_pin_oe_o == $past(lock_loss_pin_enable_i)
        && lock_loss_pin_o
        == ($past(lock_loss_status_i) ~^ $past(pol_reg[1])))
        else $error("lock-loss pin wrong");
    AST_ACTIVE_PIN: assert property (!sys_rst_i |=>
        clock_select_or_active_pin_oe_o == $past(clock_active_pin_enable_i)
        && clock_select_or_active_pin_o
        == ($past(clock_active_i) ~^ $past(pol_reg[3])))
        else $error("clock-active pin wrong");
    AST_READ: assert property (reg_rd_i |=>
        reg_rdata_o == $past(rd_calc)) else $error("read data wrong");
    AST_READ_HOLD: assert property (!reg_rd_i |=>
        $stable(reg_rdata_o)) else $error("read data moved without read");
    AST_DIV_RATIO: assert property (!sys_rst_i |=>
        highspeed_output_divider_code_o == $past(div_reg[7:5])
        && highspeed_divide_ratio_o == 4'h4 + {1'b0, $past(div_reg[7:5])})
        else $error("divider code or ratio wrong");
endmodule
bind aplp_alarm_config aplp_alarm_config_chk #(.ADDR_W(ADDR_W)) u_chk (.*);

// ===== sim/aplp_board_monitor.sv
// board side of the status pins: pull-ups on every released pin
`timescale 1ns/1ps
module aplp_board_monitor (
    // pin levels and enables: [3] shared, [2] second bad, [1] active, [0] lock
    input wire logic [3:0] pin_i,
    input wire logic [3:0] oe_i,
    // levels seen on the board wires
    output logic [3:0] wire_o
);
    // a tristated pin floats up, so it reads high whatever level was last driven
    assign wire_o = (pin_i & oe_i) | ~oe_i;
endmodule

// ===== sim/aplp_alarm_config_bench.sv
// self-checking bench for the alarm polarity, mask and divider block
`timescale 1ns/1ps
module aplp_alarm_config_bench;
    // clock, reset and register port
    logic clk_i, sys_rst_i, reg_wr_i, reg_rd_i;
    logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
    // flags, status levels and pin enables (int, bad1, bad2, lock, active)
    logic [2:0] los_f, ofs_f;
    logic fcb, scb, cact, lstat;
    logic [4:0] en;
    // pin levels, enables, board wires and summaries
    logic [3:0] pin, oe, bw;
    logic irq;
    logic [2:0] code;
    logic [3:0] ratio;
    int bad_count = 0;
    int total_checks = 0;
    aplp_alarm_config u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .signal_loss_flags_i(los_f), .offset_lock_flags_i(ofs_f),
        .first_clock_bad_i(fcb), .second_clock_bad_i(scb),
        .clock_active_i(cact), .lock_loss_status_i(lstat),
        .interrupt_pin_enable_i(en[0]), .first_clock_bad_pin_enable_i(en[1]),
        .second_clock_bad_pin_enable_i(en[2]),
        .lock_loss_pin_enable_i(en[3]), .clock_active_pin_enable_i(en[4]),
        .interrupt_or_first_clock_bad_pin_o(pin[3]),
        .interrupt_or_first_clock_bad_pin_oe_o(oe[3]),
        .second_clock_bad_pin_o(pin[2]), .second_clock_bad_pin_oe_o(oe[2]),
        .clock_select_or_active_pin_o(pin[1]),
        .clock_select_or_active_pin_oe_o(oe[1]),
        .lock_loss_pin_o(pin[0]), .lock_loss_pin_oe_o(oe[0]),
        .interrupt_o(irq), .highspeed_output_divider_code_o(code),
        .highspeed_divide_ratio_o(ratio));
    aplp_board_monitor u_board (.pin_i(pin), .oe_i(oe), .wire_o(bw));
    // free-running clock, 100 ns period
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    // compare one value and count it
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    // one-cycle write strobe
    task reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask
    // one-cycle read strobe, data checked after the taking edge
    task reg_rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        #1 chk(reg_rdata_o, exp);
    endtask
    // let the two-cycle pin path settle
    task settle();
        repeat (3) @(posedge clk_i);
        #1;
    endtask
    // reset values, an unmapped read, then reserved bits under writes
    task t_registers();
        logic [7:0] lo [4];
        logic [7:0] hi [4];
        lo = '{8'hD0, 8'h18, 8'h38, 8'h00};
        hi = '{8'hDF, 8'h1F, 8'h3F, 8'hE0};
        // reset contents of the four registers
        reg_rd(aplp_pkg::OFS_POLARITY, aplp_pkg::RST_POLARITY);
        reg_rd(aplp_pkg::OFS_LOSS_MASK, aplp_pkg::RST_LOSS_MASK);
        reg_rd(aplp_pkg::OFS_OFFSET_MASK, aplp_pkg::RST_OFFSET_MASK);
        reg_rd(aplp_pkg::OFS_HS_DIVIDER, aplp_pkg::RST_HS_DIVIDER);
        chk(ratio, 8'h05);
        reg_rd(8'h1A, 8'h00);
        for (int i = 0; i < 4; i++) begin
            reg_wr(8'(8'h16 + i), 8'h00);
            reg_rd(8'(8'h16 + i), lo[i]);
            reg_wr(8'(8'h16 + i), 8'hFF);
            reg_rd(8'(8'h16 + i), hi[i]);
        end
    endtask
    // every divider code gives code plus four
    task t_divider();
        for (int c = 0; c < 8; c++) begin
            reg_wr(8'h19, 8'(c << 5));
            settle();
            chk(code, 8'(c));
            chk(ratio, 8'(c + 4));
        end
    endtask
    // each flag raises, is masked, then counts again once unmasked
    task t_masks();
        logic [7:0] a, m;
        @(posedge clk_i) en <= 5'h1F;
        reg_wr(8'h16, 8'h0F);
        reg_wr(8'h17, 8'h00);
        reg_wr(8'h18, 8'h00);
        for (int i = 0; i < 6; i++) begin
            a = (i < 3) ? 8'h17 : 8'h18;
            m = 8'(1 << (i % 3));
            @(posedge clk_i) {ofs_f, los_f} <= 6'(1 << i);
            settle();
            chk(irq, 8'h01);
            chk(bw[3], 8'h01);
            reg_wr(a, m);
            settle();
            chk(irq, 8'h00);
            chk(bw[3], 8'h00);
            reg_wr(a, 8'h00);
            settle();
            chk(irq, 8'h01);
        end
        // active-low interrupt pin
        reg_wr(8'h16, 8'h0E);
        settle();
        chk(bw[3], 8'h00);
        @(posedge clk_i) {ofs_f, los_f} <= 6'h00;
        settle();
        chk(bw[3], 8'h01);
        chk(oe[3], 8'h01);
    endtask
    // status pin polarity, then every pin released
    task t_pins();
        @(posedge clk_i) en <= 5'h1E;
        for (int p = 0; p < 2; p++) begin
            reg_wr(8'h16, p ? 8'h0F : 8'h00);
            for (int s = 0; s < 2; s++) begin
                @(posedge clk_i) {fcb, scb, cact, lstat} <= {4{s[0]}};
                settle();
                chk(bw, {4{s[0] ~^ p[0]}});
            end
        end
        @(posedge clk_i) en <= 5'h00;
        settle();
        chk(oe, 8'h00);
        chk(bw, 8'h0F);
    endtask
    // print the counts and the verdict, then stop
    task finish_test();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // watchdog well beyond the expected run length
    initial begin
        repeat (5000) @(posedge clk_i);
        bad_count++;
        finish_test();
    end
    // main sequence
    initial begin
        sys_rst_i = 1'b1;
        {reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} = '0;
        {los_f, ofs_f, fcb, scb, cact, lstat} = '0;
        en = 5'h1F;
        repeat (2) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        t_registers();
        t_divider();
        t_masks();
        t_pins();
        finish_test();
    end
endmodule
